// ---- flash_host_pkg.sv ----
package flash_host_pkg;

  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] ADDR_OFS   = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] WINCNT_OFS = 8'h0C;

  // control word: command code in [2:0], a write starts it unless the command is refused
  localparam int CMD_LSB = 0;
  localparam int CMD_MSB = 2;

  // status word fields
  localparam int ST_BUSY    = 0;
  localparam int ST_READY   = 1;
  localparam int ST_WINDOW  = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_RD_LSB  = 16;

  // host commands
  localparam logic [2:0] CMD_CHIP_ERASE = 3'h0;
  localparam logic [2:0] CMD_SECT_ERASE = 3'h1;
  localparam logic [2:0] CMD_ADD_SECTOR = 3'h2;
  localparam logic [2:0] CMD_SUSPEND    = 3'h3;
  localparam logic [2:0] CMD_RESUME     = 3'h4;
  localparam logic [2:0] CMD_RESET      = 3'h5;
  localparam logic [2:0] CMD_HW_RESET   = 3'h6;
  localparam logic [2:0] CMD_READ       = 3'h7;

  // flash command codes, word mode
  localparam logic [15:0] UNLOCK1_ADDR = 16'h0555;
  localparam logic [15:0] UNLOCK2_ADDR = 16'h02AA;
  localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] SETUP_DATA   = 16'h0080;
  localparam logic [15:0] CHIP_DATA    = 16'h0010;
  localparam logic [15:0] SECTOR_DATA  = 16'h0030;
  localparam logic [15:0] SUSPEND_DATA = 16'h00B0;
  localparam logic [15:0] RESUME_DATA  = 16'h0030;
  localparam logic [15:0] RESET_DATA   = 16'h00F0;

  // sector is a20..a12, bank is a20..a18
  localparam logic [20:0] SECTOR_MASK = 21'h1FF000;
  localparam logic [20:0] BANK_MASK   = 21'h1C0000;

  // timing at 40 mhz
  localparam int CLOCK_KHZ  = 40000;
  localparam int WINDOW_US  = 50;
  localparam int WINDOW_CYC = WINDOW_US * CLOCK_KHZ / 1000;
  localparam int HWRST_NS   = 500;
  localparam int HWRST_CYC  = (HWRST_NS * CLOCK_KHZ + 999999) / 1000000;
  localparam int STROBE_NS  = 50;
  localparam int STROBE_CYC = (STROBE_NS * CLOCK_KHZ + 999999) / 1000000;
  // read strobe stretched to cover the two-flop input sampler
  localparam int READ_CYC   = STROBE_CYC + 3;

endpackage : flash_host_pkg

// ---- flash_bus_cycle.sv ----
`timescale 1ns/10ps
module flash_bus_cycle
  import flash_host_pkg::*;
(
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  // request
  input  wire logic                       start,
  input  wire logic                       writeEn,
  input  wire logic [flash_host_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic [flash_host_pkg::DATA_W-1:0] reqData,
  output logic                            done,
  output logic [7:0]                      readByte,
  // flash strobes
  input  wire logic [flash_host_pkg::DATA_W-1:0] dqSync,
  output logic [flash_host_pkg::ADDR_W-1:0] flashAddr,
  output logic [flash_host_pkg::DATA_W-1:0] flashDqOut,
  output logic                            flashDqOe,
  output logic                            flashCeN,
  output logic                            flashWeN,
  output logic                            flashOeN
);
  import flash_host_pkg::*;

  typedef enum logic [3:0] {
    CY_IDLE   = 4'b0001,
    CY_SETUP  = 4'b0010,
    CY_STROBE = 4'b0100,
    CY_HOLD   = 4'b1000
  } cycle_e;

  cycle_e     state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic       wr_q, wr_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] dout_q, dout_d;
  logic       oe_q, oe_d, ceN_q, ceN_d, weN_q, weN_d, rdN_q, rdN_d, done_q, done_d;
  logic [7:0] rbyte_q, rbyte_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    wr_d    = wr_q;
    addr_d  = addr_q;
    dout_d  = dout_q;
    oe_d    = oe_q;
    ceN_d   = ceN_q;
    weN_d   = weN_q;
    rdN_d   = rdN_q;
    done_d  = 1'b0;
    rbyte_d = rbyte_q;
    case (state_q)
      CY_IDLE: begin
        if (start) begin
          wr_d    = writeEn;
          addr_d  = reqAddr;
          dout_d  = reqData;
          oe_d    = writeEn;
          ceN_d   = 1'b0;
          state_d = CY_SETUP;
        end
      end
      CY_SETUP: begin
        // address settles a cycle before either strobe falls
        weN_d   = ~wr_q;
        rdN_d   = wr_q;
        cnt_d   = wr_q ? 4'(STROBE_CYC - 1) : 4'(READ_CYC - 1);
        state_d = CY_STROBE;
      end
      CY_STROBE: begin
        if (cnt_q == 4'h0) begin
          // rising edge of the write strobe latches the command
          weN_d   = 1'b1;
          rdN_d   = 1'b1;
          rbyte_d = wr_q ? rbyte_q : dqSync[7:0];
          state_d = CY_HOLD;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      CY_HOLD: begin
        ceN_d   = 1'b1;
        oe_d    = 1'b0;
        done_d  = 1'b1;
        state_d = CY_IDLE;
      end
      default: state_d = CY_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_q <= CY_IDLE;
      cnt_q   <= 4'h0;
      wr_q    <= 1'b0;
      addr_q  <= '0;
      dout_q  <= '0;
      oe_q    <= 1'b0;
      ceN_q   <= 1'b1;
      weN_q   <= 1'b1;
      rdN_q   <= 1'b1;
      done_q  <= 1'b0;
      rbyte_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      wr_q    <= wr_d;
      addr_q  <= addr_d;
      dout_q  <= dout_d;
      oe_q    <= oe_d;
      ceN_q   <= ceN_d;
      weN_q   <= weN_d;
      rdN_q   <= rdN_d;
      done_q  <= done_d;
      rbyte_q <= rbyte_d;
    end
  end

  assign flashAddr  = addr_q;
  assign flashDqOut = dout_q;
  assign flashDqOe  = oe_q;
  assign flashCeN   = ceN_q;
  assign flashWeN   = weN_q;
  assign flashOeN   = rdN_q;
  assign done       = done_q;
  assign readByte   = rbyte_q;

  a_we_width: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(flashWeN) |-> !flashWeN [*2]) else $error("write strobe too short");
  a_we_drive: assert property (@(posedge clock) disable iff (!reset_n)
    !flashWeN |-> flashDqOe && !flashCeN && flashOeN) else $error("write strobe without data drive");
  a_no_contend: assert property (@(posedge clock) disable iff (!reset_n)
    !flashOeN |-> !flashDqOe) else $error("bus driven during read");
  c_write_cycle: cover property (@(posedge clock) disable iff (!reset_n) $rose(flashWeN));

endmodule : flash_bus_cycle

// ---- flash_erase_host.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// - chip erase: six writes, last starts erasing
// - reset pin aborts; host reissues whole sequence
// - sector erase: six writes, last sector/30h
// - added sectors spaced under 50 us
// - in window only 30h, B0h, F0h written
// - suspend B0h to bank holding erasing sector
// - resume to suspended bank, repeats ignored
// - host avoids programming extra region suspended
// - sector chosen only by a20..a12
// - bank chosen only by a20..a18
module flash_erase_host (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  // flash pins
  output logic [flash_host_pkg::ADDR_W-1:0] flashAddr,
  output logic [flash_host_pkg::DATA_W-1:0] flashDqOut,
  output logic                            flashDqOe,
  input  wire logic [flash_host_pkg::DATA_W-1:0] flashDqIn,
  output logic                            flashCeN,
  output logic                            flashWeN,
  output logic                            flashOeN,
  output logic                            flashResetN,
  input  wire logic                       readyBusy_n
);
  import flash_host_pkg::*;

  typedef enum logic [3:0] {
    HS_IDLE  = 4'b0001,
    HS_ISSUE = 4'b0010,
    HS_WAIT  = 4'b0100,
    HS_HWRST = 4'b1000
  } host_e;

  // one command word: address then data
  function automatic logic [ADDR_W+DATA_W-1:0] seqWord(input logic [2:0] cmd, input logic [2:0] step,
                                                        input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] sect;
    logic [ADDR_W-1:0] bank;
    sect = a & SECTOR_MASK;
    bank = a & BANK_MASK;
    case (cmd)
      CMD_CHIP_ERASE, CMD_SECT_ERASE: begin
        case (step)
          3'h0, 3'h3: seqWord = {21'(UNLOCK1_ADDR), UNLOCK1_DATA};
          3'h1, 3'h4: seqWord = {21'(UNLOCK2_ADDR), UNLOCK2_DATA};
          3'h2:       seqWord = {21'(UNLOCK1_ADDR), SETUP_DATA};
          default:    seqWord = (cmd == CMD_CHIP_ERASE) ? {21'(UNLOCK1_ADDR), CHIP_DATA}
                                                        : {sect, SECTOR_DATA};
        endcase
      end
      CMD_ADD_SECTOR: seqWord = {sect, SECTOR_DATA};
      CMD_SUSPEND:    seqWord = {bank, SUSPEND_DATA};
      CMD_RESUME:     seqWord = {bank, RESUME_DATA};
      CMD_RESET:      seqWord = {21'h000000, RESET_DATA};
      default:        seqWord = {a, 16'h0000}; // no program command exists
    endcase
  endfunction : seqWord

  function automatic logic [2:0] seqLast(input logic [2:0] cmd);
    seqLast = (cmd == CMD_CHIP_ERASE || cmd == CMD_SECT_ERASE) ? 3'h5 : 3'h0;
  endfunction : seqLast

  // pin inputs pass two flops; only the second is read
  logic [DATA_W-1:0] dqMeta_q, dqSync_q;
  logic              rbMeta_q, rbSync_q;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dqMeta_q <= '0;
      dqSync_q <= '0;
      rbMeta_q <= 1'b1;
      rbSync_q <= 1'b1;
    end else begin
      dqMeta_q <= flashDqIn;
      dqSync_q <= dqMeta_q;
      rbMeta_q <= readyBusy_n;
      rbSync_q <= rbMeta_q;
    end
  end

  host_e             state_q, state_d;
  logic [2:0]        cmd_q, cmd_d, step_q, step_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              refused_q, refused_d, window_q, window_d, rstPinN_q, rstPinN_d;
  logic [15:0]       winCnt_q, winCnt_d;
  logic [31:0]       prdata_q, prdata_d;
  logic              pready_q, pready_d, pslverr_q, pslverr_d;
  logic              cycStart, cycDone;
  logic [7:0]        readByte;
  logic              access, take, ctrlWr, cmdOk;
  logic [2:0]        newCmd;

  assign access = psel && penable && !pready_q;
  // a write lands on the edge at which the master sees pready high
  assign take   = psel && penable && pready_q && pwrite;
  assign ctrlWr = take && paddr == CTRL_OFS;
  assign newCmd = pwdata[CMD_MSB:CMD_LSB];

  always_comb begin
    // inside the window only sector adds, suspend, both resets and reads go out
    if (window_q) begin
      cmdOk = newCmd == CMD_ADD_SECTOR || newCmd == CMD_SUSPEND || newCmd == CMD_RESET
           || newCmd == CMD_HW_RESET || newCmd == CMD_READ;
    end else begin
      cmdOk = newCmd != CMD_ADD_SECTOR;
    end
    if (state_q != HS_IDLE) begin
      cmdOk = 1'b0;
    end
  end

  always_comb begin
    state_d   = state_q;
    cmd_d     = cmd_q;
    step_d    = step_q;
    addr_d    = addr_q;
    refused_d = refused_q;
    window_d  = window_q;
    winCnt_d  = winCnt_q;
    rstPinN_d = rstPinN_q;
    cycStart  = 1'b0;
    pready_d  = access;
    pslverr_d = access && !(paddr == CTRL_OFS || paddr == ADDR_OFS || paddr == STATUS_OFS
                           || paddr == WINCNT_OFS);
    prdata_d  = 32'h00000000;
    // spacing timer: later adds past this point may be lost
    if (window_q) begin
      if (winCnt_q >= 16'(WINDOW_CYC - 1)) begin
        window_d = 1'b0;
      end else begin
        winCnt_d = winCnt_q + 16'h0001;
      end
    end
    if (take && paddr == ADDR_OFS) begin
      addr_d = pwdata[ADDR_W-1:0];
    end
    if (take && paddr == STATUS_OFS && pwdata[ST_REFUSED]) begin
      refused_d = 1'b0;
    end
    if (ctrlWr && !cmdOk) begin
      refused_d = 1'b1; // set wins over a clear in the same cycle
    end
    if (access && !pwrite) begin
      case (paddr)
        CTRL_OFS:   prdata_d = {29'h0, cmd_q};
        ADDR_OFS:   prdata_d = {11'h0, addr_q};
        STATUS_OFS: prdata_d = {8'h00, readByte, 12'h000, refused_q, window_q, rbSync_q,
                                state_q != HS_IDLE};
        WINCNT_OFS: prdata_d = {16'h0000, winCnt_q};
        default:    prdata_d = 32'h00000000;
      endcase
    end
    case (state_q)
      HS_IDLE: begin
        if (ctrlWr && cmdOk) begin
          cmd_d  = newCmd;
          step_d = 3'h0;
          if (newCmd == CMD_HW_RESET) begin
            rstPinN_d = 1'b0;
            winCnt_d = 16'h0000;
            window_d = 1'b0;
            state_d  = HS_HWRST;
          end else begin
            state_d = HS_ISSUE;
          end
          if (newCmd == CMD_SUSPEND || newCmd == CMD_RESET) begin
            window_d = 1'b0;
          end
        end
      end
      HS_ISSUE: begin
        cycStart = 1'b1;
        state_d  = HS_WAIT;
      end
      HS_WAIT: begin
        if (cycDone) begin
          if (step_q == seqLast(cmd_q)) begin
            state_d = HS_IDLE;
            if (cmd_q == CMD_SECT_ERASE || cmd_q == CMD_ADD_SECTOR) begin
              // counts from the done pulse that ended the last write's bus cycle
              window_d = 1'b1;
              winCnt_d = 16'h0000;
            end
          end else begin
            step_d  = step_q + 3'h1;
            state_d = HS_ISSUE;
          end
        end
      end
      HS_HWRST: begin
        if (winCnt_q >= 16'(HWRST_CYC - 1)) begin
          rstPinN_d = 1'b1;
          winCnt_d = 16'h0000;
          state_d  = HS_IDLE;
        end else begin
          winCnt_d = winCnt_q + 16'h0001;
        end
      end
      default: state_d = HS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_q   <= HS_IDLE;
      cmd_q     <= CMD_READ;
      step_q    <= 3'h0;
      addr_q    <= '0;
      refused_q <= 1'b0;
      window_q  <= 1'b0;
      winCnt_q  <= 16'h0000;
      rstPinN_q <= 1'b1;
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cmd_q     <= cmd_d;
      step_q    <= step_d;
      addr_q    <= addr_d;
      refused_q <= refused_d;
      window_q  <= window_d;
      winCnt_q  <= winCnt_d;
      rstPinN_q <= rstPinN_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  logic [ADDR_W+DATA_W-1:0] word;
  assign word = seqWord(cmd_q, step_q, addr_q);

  flash_bus_cycle u_cycle (
    .clock      (clock),
    .reset_n    (reset_n),
    .start      (cycStart),
    .writeEn    (cmd_q != CMD_READ),
    .reqAddr    (word[ADDR_W+DATA_W-1:DATA_W]),
    .reqData    (word[DATA_W-1:0]),
    .done       (cycDone),
    .readByte   (readByte),
    .dqSync     (dqSync_q),
    .flashAddr  (flashAddr),
    .flashDqOut (flashDqOut),
    .flashDqOe  (flashDqOe),
    .flashCeN   (flashCeN),
    .flashWeN   (flashWeN),
    .flashOeN   (flashOeN)
  );

  assign flashResetN = rstPinN_q;
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;

  a_apb_answer: assert property (@(posedge clock) disable iff (!reset_n)
    psel && penable && !pready |=> pready) else $error("apb answer late");
  a_busy_refuse: assert property (@(posedge clock) disable iff (!reset_n)
    state_q == HS_WAIT && ctrlWr |=> refused_q) else $error("busy command not refused");
  a_window_refuse: assert property (@(posedge clock) disable iff (!reset_n)
    window_q && ctrlWr && newCmd == CMD_CHIP_ERASE |=> refused_q && state_q == HS_IDLE)
    else $error("command outside window set accepted");
  a_late_add: assert property (@(posedge clock) disable iff (!reset_n)
    !window_q && ctrlWr && newCmd == CMD_ADD_SECTOR |=> refused_q) else $error("late add accepted");
  a_window_bound: assert property (@(posedge clock) disable iff (!reset_n)
    window_q |-> winCnt_q < 16'd2000) else $error("window timer overran");
  a_reset_pulse: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(flashResetN) |-> !flashResetN [*8]) else $error("reset pulse too short");
  a_suspend_bank: assert property (@(posedge clock) disable iff (!reset_n)
    !flashWeN && flashDqOut == 16'h00B0 |-> flashAddr[17:0] == 18'h00000)
    else $error("suspend address not bank only");
  a_sector_mask: assert property (@(posedge clock) disable iff (!reset_n)
    !flashWeN && flashDqOut == 16'h0030 |-> flashAddr[11:0] == 12'h000)
    else $error("sector address has low bits");
  a_window_open: assert property (@(posedge clock) disable iff (!reset_n)
    state_q == HS_WAIT && cycDone && cmd_q == CMD_SECT_ERASE && step_q == 3'h5 |=> window_q)
    else $error("window not opened");

  c_chip_erase: cover property (@(posedge clock) disable iff (!reset_n)
    cycDone && cmd_q == CMD_CHIP_ERASE && step_q == 3'h5);
  c_add_sector: cover property (@(posedge clock) disable iff (!reset_n)
    cycDone && cmd_q == CMD_ADD_SECTOR);
  c_suspend_win: cover property (@(posedge clock) disable iff (!reset_n)
    window_q && ctrlWr && newCmd == CMD_SUSPEND);
  c_hw_reset: cover property (@(posedge clock) disable iff (!reset_n) $rose(flashResetN));

endmodule : flash_erase_host

// ---- flash_device_model.sv ----
`timescale 1ns/10ps
module flash_device_model
  import flash_host_pkg::*;
#(
  parameter int ERASE_CYC = 400
)(
  // clock and flash pins
  input  wire logic                              clock,
  input  wire logic [flash_host_pkg::ADDR_W-1:0] flashAddr,
  input  wire logic [flash_host_pkg::DATA_W-1:0] flashDqOut,
  input  wire logic                              flashDqOe,
  output logic      [flash_host_pkg::DATA_W-1:0] flashDqIn,
  input  wire logic                              flashCeN,
  input  wire logic                              flashWeN,
  input  wire logic                              flashOeN,
  input  wire logic                              flashResetN,
  output logic                                   readyBusy_n
);
  import flash_host_pkg::*;
  logic [20:0]  logA [0:63];
  logic [15:0]  logD [0:63];
  logic [7:0]   hd   [0:4];
  logic [20:0]  ha   [0:4];
  int           logN = 0, eraseCnt = 0, winCnt = 0;
  logic         weQ = 1, oeQ = 1, chipMode = 0, suspended = 0, tog = 0;
  logic [511:0] sel = '0;
  logic [20:0]  bankQ = '0;
  logic [15:0]  lastQ = '0;
  logic [7:0]   d;
  wire drive = !flashOeN && !flashCeN && !flashDqOe;
  wire hit   = sel[flashAddr[20:12]] && eraseCnt > 0;
  wire unlk  = {hd[0], hd[1], hd[2], hd[3], hd[4]} == 40'hAA5580AA55 && ha[0][10:0] == 11'h555 &&
               ha[1][10:0] == 11'h2AA && ha[2][10:0] == 11'h555 && ha[3][10:0] == 11'h555 &&
               ha[4][10:0] == 11'h2AA;
  // released bus shows the inverse of the last value so a stale sample cannot pass
  always_comb flashDqIn = drive ? (hit ? (suspended ? 16'h0084 : {9'h0, tog, 6'h0}) :
                          {8'h00, flashAddr[7:0] ^ 8'hA5}) : ~lastQ;
  assign readyBusy_n = !(eraseCnt > 0 && !suspended);
  always @(posedge clock) begin
    weQ <= flashWeN;
    oeQ <= flashOeN;
    if (drive) lastQ <= flashDqIn;
    if (flashOeN && !oeQ && hit && !suspended) tog <= ~tog;
    if (!flashResetN) begin
      eraseCnt  <= 0;
      winCnt    <= 0;
      suspended <= 0;
      sel       <= '0;
    end else if (flashWeN && !weQ && !flashCeN) begin
      d = flashDqOut[7:0];
      logA[logN] <= flashAddr;
      logD[logN] <= flashDqOut;
      logN <= logN + 1;
      for (int k = 0; k < 4; k++) begin
        hd[k] <= hd[k+1];
        ha[k] <= ha[k+1];
      end
      hd[4] <= d;
      ha[4] <= flashAddr;
      if (eraseCnt > 0 && chipMode) begin
      end else if (winCnt > 0) begin
        if (d == 8'h30) begin
          sel[flashAddr[20:12]] <= 1'b1;
          winCnt <= WINDOW_CYC;
        end else if (d == 8'hB0) begin
          winCnt    <= 0;
          suspended <= 1'b1;
        end else if (d == 8'hF0) begin
          winCnt   <= 0;
          eraseCnt <= 0;
        end
      end else if (eraseCnt > 0) begin
        if (!suspended && d == 8'hB0 && (flashAddr & BANK_MASK) == bankQ) suspended <= 1'b1;
        else if (suspended && d == 8'h30 && (flashAddr & BANK_MASK) == bankQ) suspended <= 1'b0;
      end else if (unlk && d == 8'h10 && flashAddr[10:0] == 11'h555) begin
        chipMode <= 1'b1;
        eraseCnt <= ERASE_CYC;
        sel      <= '1;
      end else if (unlk && d == 8'h30) begin
        chipMode <= 1'b0;
        eraseCnt <= ERASE_CYC;
        winCnt   <= WINDOW_CYC;
        sel      <= '0;
        sel[flashAddr[20:12]] <= 1'b1;
        bankQ    <= flashAddr & BANK_MASK;
      end
    end else if (winCnt > 0) winCnt <= winCnt - 1;
    else if (eraseCnt > 0 && !suspended) eraseCnt <= eraseCnt - 1;
  end
endmodule : flash_device_model

// ---- flash_erase_command_sequencer_bench.sv ----
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin badCount++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module flash_erase_command_sequencer_bench;
  import flash_host_pkg::*;
  logic              clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]        paddr = '0;
  logic [31:0]       pwdata = '0, prdata, r;
  logic              pready, pslverr, e, flashDqOe, flashCeN, flashWeN, flashOeN, flashResetN, readyBusy_n;
  logic [ADDR_W-1:0] flashAddr, a1, a2;
  logic [DATA_W-1:0] flashDqOut, flashDqIn;
  logic [10:0]       exA [0:4] = '{11'h555, 11'h2AA, 11'h555, 11'h555, 11'h2AA};
  logic [15:0]       exD [0:4] = '{16'h00AA, 16'h0055, 16'h0080, 16'h00AA, 16'h0055};
  int                badCount = 0, totalChecks = 0, lowCnt = 0, st, i;
  int                seed = 32'h5AF6;
  flash_erase_host uut (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .flashAddr, .flashDqOut, .flashDqOe, .flashDqIn, .flashCeN, .flashWeN, .flashOeN, .flashResetN, .readyBusy_n);
  // long erase so the hardware reset lands while erasing
  flash_device_model #(.ERASE_CYC(1500)) dev (.clock, .flashAddr, .flashDqOut, .flashDqOe, .flashDqIn,
    .flashCeN, .flashWeN, .flashOeN, .flashResetN, .readyBusy_n);
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) if (flashResetN === 1'b0) lowCnt <= lowCnt + 1;
  function automatic logic [7:0] expArray(input logic [20:0] ad);
    return ad[7:0] ^ 8'hA5;
  endfunction : expArray
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= ad; pwdata <= wd;
    @(posedge clock);
    penable <= 1;
    n = 0;
    do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) badCount++;
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic cmd(input logic [2:0] c, input logic [20:0] ad);
    int n;
    apb(1'b1, ADDR_OFS, {11'h0, ad});
    apb(1'b1, CTRL_OFS, {29'h0, c});
    n = 0;
    do begin apb(1'b0, STATUS_OFS, 0); n++; end while (r[ST_BUSY] !== 1'b0 && n < 200);
    if (r[ST_BUSY] !== 1'b0) badCount++;
  endtask : cmd
  task automatic chkLog(input int k, input logic [20:0] ea, input logic [15:0] ed, input logic [20:0] m);
    `CHK("flash address", ea & m, dev.logA[k] & m)
    `CHK("flash data", ed, dev.logD[k])
  endtask : chkLog
  task close_out;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1;
    apb(1'b0, CTRL_OFS, 0); `CHK("ctrl reset", {29'h0, CMD_READ}, r)
    apb(1'b0, STATUS_OFS, 0); `CHK("status reset", 32'h2, r)
    apb(1'b0, WINCNT_OFS, 0); `CHK("wincnt reset", 32'h0, r)
    `CHK("reset pin idle", 1'b1, flashResetN)
    apb(1'b0, 8'h10, 0); `CHK("unmapped error", 1'b1, e)
    st = dev.logN;
    cmd(CMD_CHIP_ERASE, 21'h0);
    for (i = 0; i < 5; i++) chkLog(st + i, exA[i], exD[i], 21'h7FF);
    chkLog(st + 5, 21'h555, 16'h0010, 21'h7FF);
    // ready/busy needs two synchroniser cycles after the last write
    apb(1'b0, STATUS_OFS, 0); `CHK("busy in chip erase", 1'b0, r[ST_READY])
    cmd(CMD_SUSPEND, 21'h0); `CHK("chip erase kept", 1'b0, dev.suspended)
    repeat (1600) @(posedge clock);
    apb(1'b0, STATUS_OFS, 0); `CHK("ready after erase", 1'b1, r[ST_READY])
    for (i = 0; i < 3; i++) begin
      a1 = 21'($random(seed));
      cmd(CMD_READ, a1); `CHK("array read", expArray(a1), r[ST_RD_LSB +: 8])
    end
    a1 = 21'($random(seed));
    a2 = {a1[20:18], ~a1[17:12], 12'h0};
    st = dev.logN;
    cmd(CMD_SECT_ERASE, a1);
    for (i = 0; i < 5; i++) chkLog(st + i, exA[i], exD[i], 21'h7FF);
    chkLog(st + 5, a1, 16'h0030, SECTOR_MASK);
    `CHK("window open", 1'b1, r[ST_WINDOW])
    cmd(CMD_ADD_SECTOR, a2); chkLog(st + 6, a2, 16'h0030, SECTOR_MASK);
    `CHK("sector added", 1'b1, dev.sel[a2[20:12]])
    cmd(CMD_CHIP_ERASE, 21'h0); `CHK("refused in window", 1'b1, r[ST_REFUSED])
    `CHK("nothing sent", st + 7, dev.logN)
    apb(1'b1, STATUS_OFS, 32'h8);
    cmd(CMD_SUSPEND, a2); chkLog(st + 7, a2, 16'h00B0, BANK_MASK);
    `CHK("window ended", 2'b00, r[ST_REFUSED:ST_WINDOW])
    `CHK("suspended", 1'b1, dev.suspended)
    cmd(CMD_READ, a2); `CHK("suspended status", 8'h84, r[ST_RD_LSB +: 8])
    a1 = {~a1[20:18], a1[17:0]};
    cmd(CMD_READ, a1); `CHK("other bank read", expArray(a1), r[ST_RD_LSB +: 8])
    cmd(CMD_RESUME, a2); chkLog(st + 8, a2, 16'h0030, BANK_MASK);
    `CHK("resumed", 1'b0, dev.suspended)
    cmd(CMD_ADD_SECTOR, a1); `CHK("late add refused", 1'b1, r[ST_REFUSED])
    cmd(CMD_SUSPEND, a2); `CHK("second suspend", 1'b1, dev.suspended)
    cmd(CMD_RESUME, a2);
    cmd(CMD_RESUME, a2); `CHK("repeat resume", 1'b0, dev.suspended)
    st = lowCnt;
    cmd(CMD_HW_RESET, 21'h0); `CHK("reset pulse", HWRST_CYC, lowCnt - st)
    apb(1'b0, STATUS_OFS, 0); `CHK("erase aborted", 1'b1, r[ST_READY])
    st = dev.logN;
    cmd(CMD_RESET, 21'h0); chkLog(st, 21'h0, 16'h00F0, 21'h1FFFFF);
    close_out;
  end
  initial begin
    repeat (60000) @(posedge clock);
    badCount++;
    close_out;
  end
endmodule : flash_erase_command_sequencer_bench
